//--- hw/fdp_pkg.sv
package fdp_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;
   localparam int BYTE_W = 8;
   localparam int NUM_SLOTS = 9;
   localparam int SLOT_W = 4;
   localparam int IDX_W = 6;
   localparam int ADDR_LSB = 2;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CH0_NUM_LOW = 6'h31;
   localparam logic [IDX_W-1:0] IDX_CH1_DEN_MID = 6'h32;
   localparam logic [IDX_W-1:0] IDX_CH1_DEN_LOW = 6'h33;
   localparam logic [IDX_W-1:0] IDX_CH1_POSTDIV_INT_TOP = 6'h34;
   localparam logic [IDX_W-1:0] IDX_CH1_INT_MID = 6'h35;
   localparam logic [IDX_W-1:0] IDX_CH1_INT_LOW = 6'h36;
   localparam logic [IDX_W-1:0] IDX_CH1_FRAC_TOP = 6'h37;
   localparam logic [IDX_W-1:0] IDX_CH1_NUM_MID = 6'h38;
   localparam logic [IDX_W-1:0] IDX_CH1_NUM_LOW = 6'h39;
   localparam logic [IDX_W-1:0] IDX_FIRST = IDX_CH0_NUM_LOW;
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_CH1_NUM_LOW;

   localparam logic [SLOT_W-1:0] SLOT_CH0_NUM_LOW = 4'h0;
   localparam logic [SLOT_W-1:0] SLOT_CH1_DEN_MID = 4'h1;
   localparam logic [SLOT_W-1:0] SLOT_CH1_DEN_LOW = 4'h2;
   localparam logic [SLOT_W-1:0] SLOT_CH1_POSTDIV_INT_TOP = 4'h3;
   localparam logic [SLOT_W-1:0] SLOT_CH1_INT_MID = 4'h4;
   localparam logic [SLOT_W-1:0] SLOT_CH1_INT_LOW = 4'h5;
   localparam logic [SLOT_W-1:0] SLOT_CH1_FRAC_TOP = 4'h6;
   localparam logic [SLOT_W-1:0] SLOT_CH1_NUM_MID = 4'h7;
   localparam logic [SLOT_W-1:0] SLOT_CH1_NUM_LOW = 4'h8;

   // field layout
   localparam int INT_TOP_LSB = 0;
   localparam int INT_TOP_W = 2;
   localparam int POSTDIV_LSB = 4;
   localparam int POSTDIV_W = 3;
   localparam int NUM_TOP_LSB = 0;
   localparam int DEN_TOP_LSB = 4;
   localparam int NIB_W = 4;
   localparam int INT_PARAM_W = 18;
   localparam int FRAC_PARAM_W = 20;
   localparam int RATIO_W = 8;

   localparam logic [BYTE_W-1:0] MASK_FULL = 8'hff;
   localparam logic [BYTE_W-1:0] MASK_POSTDIV_INT_TOP = 8'h73;
   localparam logic [BYTE_W-1:0] RESET_BYTE = 8'h00;
   localparam logic [RATIO_W-1:0] RATIO_ONE = 8'h01;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // writable bits of each slot; everything else stores zero
   function automatic logic [BYTE_W-1:0] fdp_write_mask(
      input logic [SLOT_W-1:0] slot);
      fdp_write_mask = (slot == SLOT_CH1_POSTDIV_INT_TOP) ?
                       MASK_POSTDIV_INT_TOP : MASK_FULL;
   endfunction : fdp_write_mask

   // returns {hit, slot}
   function automatic logic [SLOT_W:0] fdp_decode(
      input logic [ADDR_W-1:0] addr);
      logic [IDX_W-1:0] idx;
      logic [IDX_W-1:0] diff;
      logic hit;
      idx = addr[ADDR_W-1:ADDR_LSB];
      diff = idx - IDX_FIRST;
      hit = (addr[ADDR_LSB-1:0] == 2'h0) && (idx >= IDX_FIRST) &&
            (idx <= IDX_LAST);
      fdp_decode = {hit, diff[SLOT_W-1:0]};
   endfunction : fdp_decode

endpackage : fdp_pkg

//--- hw/fdp_param_store.sv
`timescale 1ns/1ns
`default_nettype none

module fdp_param_store
   import fdp_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [SLOT_W-1:0] wr_slot,
   input wire logic [BYTE_W-1:0] wr_data,
   input wire logic rd_en,
   input wire logic rd_hit,
   input wire logic [SLOT_W-1:0] rd_slot,
   output logic [BYTE_W-1:0] rd_data,
   output logic [NUM_SLOTS*BYTE_W-1:0] contents
);

   logic [BYTE_W-1:0] masked_wr;

   assign masked_wr = wr_data & fdp_write_mask(wr_slot);

   genvar i;
   generate
      for (i = 0; i < NUM_SLOTS; i = i + 1) begin : g_slot
         logic [BYTE_W-1:0] slot_q;
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               slot_q <= RESET_BYTE;
            end else if (ce && wr_en && (wr_slot == SLOT_W'(i))) begin
               slot_q <= masked_wr;
            end
         end
         // one flop per slot keeps a single process behind each byte
         assign contents[i*BYTE_W +: BYTE_W] = slot_q;
      end
   endgenerate

   // unmapped reads answer zero
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_data <= RESET_BYTE;
      end else if (ce && rd_en) begin
         rd_data <= rd_hit ? contents[rd_slot*BYTE_W +: BYTE_W] :
                    RESET_BYTE;
      end
   end

endmodule : fdp_param_store

`default_nettype wire

//--- hw/fdp_regs.sv
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - hold 18-bit integer parameter, top bits 1:0
// - hold 20-bit fractional numerator parameter
// - hold 20-bit denominator, mid/low bytes separate
// - denominator upper nibble in shared bits 7:4
// - numerator upper nibble in shared bits 3:0
module fdp_regs
   import fdp_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [BYTE_W-1:0] ch0_fraction_numerator_low,
   output logic [INT_PARAM_W-1:0] ch1_integer_param,
   output logic [FRAC_PARAM_W-1:0] ch1_fraction_numerator,
   output logic [FRAC_PARAM_W-1:0] ch1_fraction_denominator,
   output logic [POSTDIV_W-1:0] ch1_post_divider_select,
   output logic [RATIO_W-1:0] ch1_post_divide_ratio
);

   typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_ANSWER} fdp_rd_e;

   fdp_rd_e rd_state;
   logic [ADDR_W-1:0] aw_addr;
   logic [BYTE_W-1:0] w_byte;
   logic w_low_lane;
   logic rd_hit;
   logic [SLOT_W-1:0] rd_slot;
   logic [BYTE_W-1:0] rd_byte;
   logic [NUM_SLOTS*BYTE_W-1:0] contents;

   // awready/wready low means the address/data is held here
   wire logic wr_fire;
   wire logic [SLOT_W:0] wr_dec;
   wire logic [SLOT_W:0] rd_dec;
   wire logic wr_hit;
   wire logic wr_en;
   wire logic rd_take;
   wire logic rd_fetch;
   wire logic [BYTE_W-1:0] b_ch0_num_low;
   wire logic [BYTE_W-1:0] b_den_mid;
   wire logic [BYTE_W-1:0] b_den_low;
   wire logic [BYTE_W-1:0] b_post_int;
   wire logic [BYTE_W-1:0] b_int_mid;
   wire logic [BYTE_W-1:0] b_int_low;
   wire logic [BYTE_W-1:0] b_frac_top;
   wire logic [BYTE_W-1:0] b_num_mid;
   wire logic [BYTE_W-1:0] b_num_low;
   wire logic [POSTDIV_W-1:0] post_code;

   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_dec = fdp_decode(aw_addr);
   assign rd_dec = fdp_decode(s_axi_araddr);
   assign wr_hit = wr_dec[SLOT_W];
   // a narrow write that skips the low lane changes nothing
   assign wr_en = wr_fire && wr_hit && w_low_lane;
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign rd_fetch = (rd_state == RD_FETCH);

   fdp_param_store u_store (
      .clock(clock),
      .nrst(nrst),
      .ce(ce),
      .wr_en(wr_en),
      .wr_slot(wr_dec[SLOT_W-1:0]),
      .wr_data(w_byte),
      .rd_en(rd_fetch),
      .rd_hit(rd_hit),
      .rd_slot(rd_slot),
      .rd_data(rd_byte),
      .contents(contents)
   );

   // write channel: address and data taken in either order
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_addr <= '0;
         w_byte <= RESET_BYTE;
         w_low_lane <= 1'b0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_byte <= s_axi_wdata[BYTE_W-1:0];
            w_low_lane <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel: one cycle to fetch from the store, then answer
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_state <= RD_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         rd_hit <= 1'b0;
         rd_slot <= '0;
      end else if (ce) begin
         case (rd_state)
            RD_IDLE: begin
               if (rd_take) begin
                  rd_state <= RD_FETCH;
                  s_axi_arready <= 1'b0;
                  rd_hit <= rd_dec[SLOT_W];
                  rd_slot <= rd_dec[SLOT_W-1:0];
                  s_axi_rresp <= rd_dec[SLOT_W] ? RESP_OKAY : RESP_SLVERR;
               end
            end
            RD_FETCH: begin
               rd_state <= RD_ANSWER;
               s_axi_rvalid <= 1'b1;
            end
            RD_ANSWER: begin
               if (s_axi_rready) begin
                  rd_state <= RD_IDLE;
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
               end
            end
            default: begin
               rd_state <= RD_IDLE;
               s_axi_rvalid <= 1'b0;
               s_axi_arready <= 1'b1;
            end
         endcase
      end
   end

   // upper bits read as zero; rd_byte is a flop inside the store
   assign s_axi_rdata = {{(DATA_W-BYTE_W){1'b0}}, rd_byte};

   assign b_ch0_num_low = contents[SLOT_CH0_NUM_LOW*BYTE_W +: BYTE_W];
   assign b_den_mid = contents[SLOT_CH1_DEN_MID*BYTE_W +: BYTE_W];
   assign b_den_low = contents[SLOT_CH1_DEN_LOW*BYTE_W +: BYTE_W];
   assign b_post_int = contents[SLOT_CH1_POSTDIV_INT_TOP*BYTE_W +: BYTE_W];
   assign b_int_mid = contents[SLOT_CH1_INT_MID*BYTE_W +: BYTE_W];
   assign b_int_low = contents[SLOT_CH1_INT_LOW*BYTE_W +: BYTE_W];
   assign b_frac_top = contents[SLOT_CH1_FRAC_TOP*BYTE_W +: BYTE_W];
   assign b_num_mid = contents[SLOT_CH1_NUM_MID*BYTE_W +: BYTE_W];
   assign b_num_low = contents[SLOT_CH1_NUM_LOW*BYTE_W +: BYTE_W];

   // parameters are zero after reset, not meaningful until written
   assign ch0_fraction_numerator_low = b_ch0_num_low;
   assign ch1_integer_param = {b_post_int[INT_TOP_LSB +: INT_TOP_W],
                               b_int_mid, b_int_low};
   assign ch1_fraction_numerator = {b_frac_top[NUM_TOP_LSB +: NIB_W],
                                    b_num_mid, b_num_low};
   assign ch1_fraction_denominator = {b_frac_top[DEN_TOP_LSB +: NIB_W],
                                      b_den_mid, b_den_low};
   assign post_code = b_post_int[POSTDIV_LSB +: POSTDIV_W];
   assign ch1_post_divider_select = post_code;

   // ratio lags the select by one clock
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ch1_post_divide_ratio <= RATIO_ONE;
      end else if (ce) begin
         ch1_post_divide_ratio <= RATIO_ONE << post_code;
      end
   end

endmodule : fdp_regs

`default_nettype wire

//--- verification/fdp_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module fdp_regs_checker
   import fdp_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [POSTDIV_W-1:0] ch1_post_divider_select,
   input wire logic [RATIO_W-1:0] ch1_post_divide_ratio
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   wire logic bad_addr;
   assign bad_addr = (s_axi_araddr[1:0] != 2'h0) ||
      (s_axi_araddr[7:2] < IDX_FIRST) || (s_axi_araddr[7:2] > IDX_LAST);
   sequence wr_take;
      ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      ce && s_axi_arvalid && s_axi_arready;
   endsequence
   chk_ratio_decode: assert property (ce |=> ch1_post_divide_ratio
      == (RATIO_ONE << $past(ch1_post_divider_select)))
      else $error("post divide ratio does not follow select");
   chk_select_quiet: assert property (!$rose(s_axi_bvalid) |->
      $stable(ch1_post_divider_select))
      else $error("select changed without a write");
   chk_write_answer: assert property (wr_take |=>
      !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
      else $error("write response late or ready not dropped");
   chk_read_answer: assert property (rd_take |=>
      !s_axi_arready && !s_axi_rvalid ##1 s_axi_rvalid)
      else $error("read data not two cycles after address");
   chk_unmapped_err: assert property (rd_take ##0 bad_addr |-> ##2
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
      else $error("unmapped read not refused");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped early");
   chk_rdata_upper: assert property (s_axi_rvalid |->
      s_axi_rdata[31:8] == '0)
      else $error("upper read data bits not zero");
endmodule : fdp_regs_checker
bind fdp_regs fdp_regs_checker chk_i (.clock(clock), .nrst(nrst), .ce(ce),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .ch1_post_divider_select(ch1_post_divider_select),
   .ch1_post_divide_ratio(ch1_post_divide_ratio));
`default_nettype wire

//--- verification/fdp_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fdp_regs_tb
   import fdp_pkg::*;
;
   logic clock = 0, nrst = 0, ce = 1;
   logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wrd, bv, arr, rv;
   logic [7:0] awa = 0, ara = 0, o0, ratio, a;
   logic [31:0] wd = 0, rd, r;
   logic [3:0] ws = 0;
   logic [1:0] bresp, rresp;
   logic [17:0] oi;
   logic [19:0] onum, oden;
   logic [2:0] os;
   logic [7:0] m [9];
   int fails = 0, compares = 0, seed = 83479, i;
   always #25 clock = ~clock;
   fdp_regs dut (.clock(clock), .nrst(nrst), .ce(ce), .s_axi_awaddr(awa),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .ch0_fraction_numerator_low(o0), .ch1_integer_param(oi),
      .ch1_fraction_numerator(onum), .ch1_fraction_denominator(oden),
      .ch1_post_divider_select(os), .ch1_post_divide_ratio(ratio));
   function automatic logic hit(input logic [7:0] x);
      hit = x[1:0] == 2'h0 && x[7:2] >= 6'h31 && x[7:2] <= 6'h39;
   endfunction : hit
   task conclude;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [7:0] x, input logic [7:0] d, input logic [3:0] s);
      logic [31:0] t;
      logic ta, tw;
      t = $random(seed);
      ta = 0;
      tw = 0;
      @(posedge clock);
      awa <= x; wd <= {t[31:8], d}; ws <= s; awv <= 1; wv <= 1; br <= t[0];
      // each channel is released at the edge where its own ready is seen
      while (!(ta && tw)) begin
         @(posedge clock);
         if (awr && !ta) awv <= 0;
         if (wrd && !tw) wv <= 0;
         ta = ta || awr;
         tw = tw || wrd;
      end
      // a late bready keeps the response standing for a cycle
      while (!(bv && br)) begin
         if (bv) br <= 1;
         @(posedge clock);
      end
      br <= 0;
      chk(bresp, hit(x) ? RESP_OKAY : RESP_SLVERR);
      if (hit(x) && s[0])
         m[x[7:2] - 6'h31] = d & ((x == 8'hd0) ? 8'h73 : 8'hff);
   endtask : wr
   task rdc(input logic [7:0] x);
      logic [31:0] t;
      t = $random(seed);
      @(posedge clock);
      ara <= x; arv <= 1; rr <= t[0];
      @(posedge clock);
      while (!arr) @(posedge clock);
      arv <= 0;
      @(posedge clock);
      while (!(rv && rr)) begin
         if (rv) rr <= 1;
         @(posedge clock);
      end
      rr <= 0;
      chk(rresp, hit(x) ? RESP_OKAY : RESP_SLVERR);
      chk(rd, hit(x) ? m[x[7:2] - 6'h31] : 8'h00);
   endtask : rdc
   task outs;
      #1;
      chk(o0, m[0]);
      chk(oi, {m[3][1:0], m[4], m[5]});
      chk(onum, {m[6][3:0], m[7], m[8]});
      chk(oden, {m[6][7:4], m[1], m[2]});
      chk(os, m[3][6:4]);
      chk(ratio, 8'h01 << m[3][6:4]);
   endtask : outs
   initial begin
      #(50 * 8000);
      fails++;
      conclude;
   end
   initial begin
      for (i = 0; i < 9; i++) m[i] = 8'h00;
      repeat (10) @(posedge clock);
      nrst <= 1;
      outs;
      $display("test reset done");
      // every parameter is written before the outputs are relied on
      for (i = 0; i < 9; i++)
         wr(8'hc4 + 8'(4 * i), 8'($random(seed)), 4'h1);
      outs;
      $display("test program done");
      for (i = 0; i < 8; i++) begin
         wr(8'hd0, {1'b1, 3'(i), 4'hf}, 4'h1);
         outs;
         rdc(8'hd0);
      end
      $display("test post divider done");
      for (i = 0; i < 60; i++) begin
         r = $random(seed);
         a = {6'h30 + 6'(r[3:0]), r[5:4] & {2{&r[7:6]}}};
         wr(a, r[23:16], r[11:8]);
         rdc({6'h30 + 6'(r[27:24]), 2'h0});
         outs;
      end
      $display("test random done");
      conclude;
   end
endmodule : fdp_regs_tb
`default_nettype wire
